// file: charger_i2c_pkg.sv
package charger_i2c_pkg;

  typedef logic [7:0] byte_type;

  // Seven-bit target address; with a zero direction bit it forms D6H.
  localparam logic [6:0] TARGET_ADDR = 7'h6B;

  // Register indices.
  localparam byte_type IDX_CHARGER_CONTROL_STATUS = 8'h00;
  localparam byte_type IDX_CHARGER_CONTROL_SECOND = 8'h01;
  localparam byte_type IDX_OUTPUT_VOLTAGE_SETTING = 8'h02;
  localparam byte_type IDX_PART_INFORMATION = 8'h03;
  localparam byte_type IDX_BATTERY_CURRENT_SETTING = 8'h04;
  localparam byte_type IDX_INPUT_VOLTAGE_CONTROL = 8'h05;
  localparam byte_type IDX_SAFETY_LIMITS = 8'h06;
  localparam byte_type IDX_POST_CHARGE_CONTROL = 8'h07;
  localparam byte_type IDX_LIVE_MONITOR_FIRST = 8'h10;
  localparam byte_type IDX_LIVE_MONITOR_SECOND = 8'h11;
  localparam byte_type IDX_THERMISTOR_CONTROL = 8'h12;
  localparam byte_type IDX_WATCHDOG_CONTROL = 8'h13;

  // Plain read/write registers, stored as one array in this order.
  localparam int NUM_RW = 8;
  localparam byte_type RW_INDEX [NUM_RW] = '{
    IDX_CHARGER_CONTROL_SECOND, IDX_OUTPUT_VOLTAGE_SETTING, IDX_BATTERY_CURRENT_SETTING,
    IDX_INPUT_VOLTAGE_CONTROL, IDX_SAFETY_LIMITS, IDX_POST_CHARGE_CONTROL,
    IDX_THERMISTOR_CONTROL, IDX_WATCHDOG_CONTROL
  };

  // Values after reset.
  localparam byte_type CONTROL_STATUS_RESET = 8'h40;
  localparam byte_type RW_RESET = 8'h00;

  // Field positions of the first control and status register.
  localparam int TIMER_RESTART_BIT = 7;
  localparam int STAT_ENABLE_BIT = 6;
  localparam logic STAT_ENABLE_RESET = CONTROL_STATUS_RESET[STAT_ENABLE_BIT];

  // Bit counter of the serial shifter.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Length of the status pin's low pulse that announces a fault.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int STAT_PULSE_TIME_NS = 1000;
  localparam int STAT_PULSE_CYCLES = (STAT_PULSE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] STAT_PULSE_COUNT = 8'(STAT_PULSE_CYCLES);

  // Serial target states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WR_BYTE = 3'b010,
    ST_WR_ACK = 3'b110,
    ST_RD_BYTE = 3'b111,
    ST_RD_ACK = 3'b101
  } i2c_state_type;

endpackage

// file: i2c_bus_events.sv
`timescale 1ns/1ps
module i2c_bus_events
  import charger_i2c_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Bus lines as seen at the pins.
  input wire logic scl_in,
  input wire logic sda_in,
  // One-cycle events.
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);

  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // A data change while the clock stays high marks a start or a stop.
  assign scl_rise_out = !scl_q && scl_in;
  assign scl_fall_out = scl_q && !scl_in;
  assign start_out = scl_q && scl_in && sda_q && !sda_in;
  assign stop_out = scl_q && scl_in && !sda_q && sda_in;

endmodule

// file: status_pin_driver.sv
`timescale 1ns/1ps
module status_pin_driver
  import charger_i2c_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Control and charger state.
  input wire logic stat_enable_in,
  input wire logic charging_in,
  input wire logic fault_event_in,
  // Status pin, active low.
  output logic stat_n_out
);

  logic [7:0] pulse_cnt_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pulse_cnt_q <= 8'h00;
    end else if (fault_event_in) begin
      pulse_cnt_q <= STAT_PULSE_COUNT;
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_q <= pulse_cnt_q - 8'h01;
    end
  end

  // Faults always pulse the pin; charging pulls it low only when enabled.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_n_out <= 1'b1;
    end else if (fault_event_in || pulse_cnt_q > 8'h01) begin
      stat_n_out <= 1'b0;
    end else begin
      stat_n_out <= !(stat_enable_in && charging_in);
    end
  end

endmodule

// file: charger_i2c_register_bank.sv
`timescale 1ns/1ps
module charger_i2c_register_bank
  import charger_i2c_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,

  // Serial bus; the data line is open drain.
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,

  // Charger status; state, boost and fault fields feed the first register, charging and the fault event drive the status pin.
  input wire logic [1:0] CHARGE_STATE_IN,
  input wire logic BOOST_ACTIVE_IN,
  input wire logic [2:0] CHARGER_FAULT_IN,
  input wire logic [2:0] BOOST_FAULT_IN,
  input wire logic CHARGING_IN,
  input wire logic FAULT_EVENT_IN,

  // Read-only register contents from the analog side.
  input wire logic [7:0] PART_INFORMATION_IN,
  input wire logic [7:0] LIVE_MONITOR_FIRST_IN,
  input wire logic [7:0] LIVE_MONITOR_SECOND_IN,

  // Control outputs.
  output logic SAFETY_TIMER_RESTART_OUT,
  output logic STAT_ENABLE_OUT,
  output logic STAT_N_OUT,

  // Read/write register contents.
  output logic [7:0] CHARGER_CONTROL_SECOND_OUT,
  output logic [7:0] OUTPUT_VOLTAGE_SETTING_OUT,
  output logic [7:0] BATTERY_CURRENT_SETTING_OUT,
  output logic [7:0] INPUT_VOLTAGE_CONTROL_OUT,
  output logic [7:0] SAFETY_LIMITS_OUT,
  output logic [7:0] POST_CHARGE_CONTROL_OUT,
  output logic [7:0] THERMISTOR_CONTROL_OUT,
  output logic [7:0] WATCHDOG_CONTROL_OUT
);

  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;

  i2c_state_type state_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] ptr_q;
  logic first_byte_q;
  logic read_q;
  logic sda_oe_q;

  logic stat_enable_q;
  logic restart_q;
  logic [7:0] rw_regs_q [NUM_RW];

  logic wr_en;
  logic [7:0] rd_data;
  logic [2:0] fault_code;
  logic [7:0] status_byte;
  logic [NUM_RW-1:0] rw_hit;
  logic bit_in;
  logic addr_done;
  logic addr_hit;
  logic ack_end;
  logic wr_done;
  logic wr_ack_end;
  logic rd_done;
  logic rd_shift;
  logic rd_next;
  logic rd_nack;
  logic load_tx;

  i2c_bus_events u_bus_events (
    .clk_in(CLK_SYS_IN),
    .arst_n_in(ARST_N_IN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_evt),
    .stop_out(stop_evt)
  );

  status_pin_driver u_status_pin (
    .clk_in(CLK_SYS_IN),
    .arst_n_in(ARST_N_IN),
    .stat_enable_in(stat_enable_q),
    .charging_in(CHARGING_IN),
    .fault_event_in(FAULT_EVENT_IN),
    .stat_n_out(STAT_N_OUT)
  );

  // The line is only ever pulled low; released, it floats high.
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_q;

  // Bus strobes. A start or a stop never falls on a bus clock edge, so they need no gating.
  assign bit_in = scl_rise && (state_q == ST_ADDR || state_q == ST_WR_BYTE);
  assign addr_done = (state_q == ST_ADDR) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
  assign addr_hit = addr_done && (shift_q[7:1] == TARGET_ADDR);
  assign ack_end = (state_q == ST_ADDR_ACK) && scl_fall;
  assign wr_done = (state_q == ST_WR_BYTE) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
  assign wr_ack_end = (state_q == ST_WR_ACK) && scl_fall;
  assign rd_done = (state_q == ST_RD_BYTE) && scl_fall && (bit_cnt_q == LAST_TX_BIT);
  assign rd_shift = (state_q == ST_RD_BYTE) && scl_fall && (bit_cnt_q != LAST_TX_BIT);
  assign rd_next = (state_q == ST_RD_ACK) && scl_fall;
  assign rd_nack = (state_q == ST_RD_ACK) && scl_rise && SDA_IN;
  assign load_tx = (ack_end && read_q) || rd_next;

  // The first byte after the address sets the pointer; later bytes are stored.
  assign wr_en = wr_done && !first_byte_q;

  // Boost operation switches the fault field to the boost coding.
  assign fault_code = BOOST_ACTIVE_IN ? BOOST_FAULT_IN : CHARGER_FAULT_IN;

  // The timer restart bit always reads as zero.
  assign status_byte = {1'b0, stat_enable_q, CHARGE_STATE_IN, BOOST_ACTIVE_IN, fault_code};

  // Read multiplexer; unlisted indices read zero.
  always_comb begin
    rd_data = 8'h00;
    case (ptr_q)
      IDX_CHARGER_CONTROL_STATUS: begin
        rd_data = status_byte;
      end
      IDX_PART_INFORMATION: begin
        rd_data = PART_INFORMATION_IN;
      end
      IDX_LIVE_MONITOR_FIRST: begin
        rd_data = LIVE_MONITOR_FIRST_IN;
      end
      IDX_LIVE_MONITOR_SECOND: begin
        rd_data = LIVE_MONITOR_SECOND_IN;
      end
      default: begin
        for (int i = 0; i < NUM_RW; i++) begin
          if (ptr_q == RW_INDEX[i]) begin
            rd_data = rw_regs_q[i];
          end
        end
      end
    endcase
  end

  // Transfer state; a start or a stop aborts whatever is in flight.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= ST_IDLE;
    end else if (stop_evt) begin
      state_q <= ST_IDLE;
    end else if (start_evt) begin
      state_q <= ST_ADDR;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_ADDR: begin
          if (addr_hit) begin
            state_q <= ST_ADDR_ACK;
          end else if (addr_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (ack_end) begin
            state_q <= read_q ? ST_RD_BYTE : ST_WR_BYTE;
          end
        end
        ST_WR_BYTE: begin
          if (wr_done) begin
            state_q <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (wr_ack_end) begin
            state_q <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (rd_done) begin
            state_q <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          if (rd_nack) begin
            state_q <= ST_IDLE;
          end else if (rd_next) begin
            state_q <= ST_RD_BYTE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive shifter for address, index and data bytes.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      shift_q <= 8'h00;
    end else if (bit_in) begin
      shift_q <= {shift_q[6:0], SDA_IN};
    end
  end

  // Bit counter; it holds at a data byte's end until the acknowledge slot is over.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      bit_cnt_q <= 4'h0;
    end else if (start_evt || addr_done || ack_end || wr_ack_end || rd_next) begin
      bit_cnt_q <= 4'h0;
    end else if (bit_in || rd_shift) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Transmit shifter; status inputs are taken live when a byte is loaded.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_q <= 8'h00;
    end else if (load_tx) begin
      tx_q <= rd_data;
    end else if (rd_shift) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      read_q <= 1'b0;
    end else if (addr_hit) begin
      read_q <= shift_q[0];
    end
  end

  // The byte after a write address is the index, not data.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      first_byte_q <= 1'b0;
    end else if (ack_end && !read_q) begin
      first_byte_q <= 1'b1;
    end else if (wr_done) begin
      first_byte_q <= 1'b0;
    end
  end

  // Register pointer; it keeps its value between transactions.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ptr_q <= 8'h00;
    end else if (wr_done && first_byte_q) begin
      ptr_q <= shift_q;
    end else if (wr_done || rd_done) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Data line driver for acknowledge slots and read bits; it changes only while the bus clock is low.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sda_oe_q <= 1'b0;
    end else if (stop_evt || start_evt) begin
      sda_oe_q <= 1'b0;
    end else if (addr_hit || wr_done) begin
      sda_oe_q <= 1'b1;
    end else if (load_tx) begin
      sda_oe_q <= !rd_data[7];
    end else if (rd_shift) begin
      sda_oe_q <= !tx_q[6];
    end else if (ack_end || wr_ack_end || rd_done || state_q == ST_IDLE) begin
      sda_oe_q <= 1'b0;
    end
  end

  // First control register: only the enable bit is stored.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stat_enable_q <= STAT_ENABLE_RESET;
    end else if (wr_en && ptr_q == IDX_CHARGER_CONTROL_STATUS) begin
      stat_enable_q <= shift_q[STAT_ENABLE_BIT];
    end
  end

  // One-cycle restart request for the safety timer.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_en && ptr_q == IDX_CHARGER_CONTROL_STATUS && shift_q[TIMER_RESTART_BIT];
    end
  end

  // Plain read/write registers; other indices, apart from the first control register, ignore writes.
  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++) begin : g_rw
      assign rw_hit[g] = wr_en && (ptr_q == RW_INDEX[g]);
      always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          rw_regs_q[g] <= RW_RESET;
        end else if (rw_hit[g]) begin
          rw_regs_q[g] <= shift_q;
        end
      end
    end
  endgenerate

  assign SAFETY_TIMER_RESTART_OUT = restart_q;
  assign STAT_ENABLE_OUT = stat_enable_q;
  assign CHARGER_CONTROL_SECOND_OUT = rw_regs_q[0];
  assign OUTPUT_VOLTAGE_SETTING_OUT = rw_regs_q[1];
  assign BATTERY_CURRENT_SETTING_OUT = rw_regs_q[2];
  assign INPUT_VOLTAGE_CONTROL_OUT = rw_regs_q[3];
  assign SAFETY_LIMITS_OUT = rw_regs_q[4];
  assign POST_CHARGE_CONTROL_OUT = rw_regs_q[5];
  assign THERMISTOR_CONTROL_OUT = rw_regs_q[6];
  assign WATCHDOG_CONTROL_OUT = rw_regs_q[7];

endmodule

// file: i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
  import charger_i2c_pkg::*;
(
  // Clock and wire.
  input wire logic clk_in,
  input wire logic sda_in,
  // Driven lines; a high data value releases the wire.
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hp();
    repeat (4) @(negedge clk_in);
  endtask
  task automatic start();
    sda_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b0;
    hp();
    scl_out = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b1;
    hp();
  endtask
  task automatic bitx(input logic b, output logic s);
    sda_out = b;
    hp();
    scl_out = 1'b1;
    hp();
    s = sda_in;
    scl_out = 1'b0;
    hp();
  endtask
  task automatic send(input byte_type d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, ack);
  endtask
  task automatic recv(output byte_type d, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, s);
  endtask
endmodule

// file: charger_bank_monitor.sv
`timescale 1ns/1ps
module charger_bank_monitor (
  // Watched ports.
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic CHARGING_IN,
  input wire logic FAULT_EVENT_IN,
  input wire logic SAFETY_TIMER_RESTART_OUT,
  input wire logic STAT_ENABLE_OUT,
  input wire logic STAT_N_OUT,
  input wire logic [7:0] CHARGER_CONTROL_SECOND_OUT,
  input wire logic [7:0] THERMISTOR_CONTROL_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence scl_fell_s;
    $past(SCL_IN, 2) && !$past(SCL_IN);
  endsequence
  sequence ack_soon_s;
    ##[0:1] SDA_OE_OUT;
  endsequence
  sequence charging_s;
    (CHARGING_IN && STAT_ENABLE_OUT)[*3];
  endsequence
  reset_value_a: assert property ($rose(ARST_N_IN) |-> STAT_ENABLE_OUT && !SDA_OE_OUT && !SDA_OUT)
    else $error("wrong state after reset");
  oe_timing_a: assert property ($changed(SDA_OE_OUT) |-> scl_fell_s)
    else $error("data enable moved off a clock fall");
  restart_pulse_a: assert property (SAFETY_TIMER_RESTART_OUT |=> !SAFETY_TIMER_RESTART_OUT)
    else $error("restart pulse too long");
  restart_ack_a: assert property (SAFETY_TIMER_RESTART_OUT |-> ack_soon_s)
    else $error("restart without a written byte");
  reg_write_a: assert property ($changed(CHARGER_CONTROL_SECOND_OUT) || $changed(THERMISTOR_CONTROL_OUT)
    |-> ack_soon_s)
    else $error("register changed without a write");
  enable_write_a: assert property ($changed(STAT_ENABLE_OUT) |-> ack_soon_s)
    else $error("status enable changed without a write");
  stat_charge_a: assert property (charging_s |-> !STAT_N_OUT)
    else $error("status pin high while charging");
  fault_pulse_a: assert property (FAULT_EVENT_IN |-> ##[1:2] !STAT_N_OUT)
    else $error("no status pulse on fault");
endmodule
bind charger_i2c_register_bank charger_bank_monitor mon (
  .CLK_SYS_IN(CLK_SYS_IN),
  .ARST_N_IN(ARST_N_IN),
  .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT),
  .CHARGING_IN(CHARGING_IN),
  .FAULT_EVENT_IN(FAULT_EVENT_IN),
  .SAFETY_TIMER_RESTART_OUT(SAFETY_TIMER_RESTART_OUT),
  .STAT_ENABLE_OUT(STAT_ENABLE_OUT),
  .STAT_N_OUT(STAT_N_OUT),
  .CHARGER_CONTROL_SECOND_OUT(CHARGER_CONTROL_SECOND_OUT),
  .THERMISTOR_CONTROL_OUT(THERMISTOR_CONTROL_OUT)
);

// file: test_charger_i2c_register_bank.sv
`timescale 1ns/1ps
module test_charger_i2c_register_bank;
  import charger_i2c_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, hsda, sda, ack, chg, flt, bst, en, stn, rs, oe, sdo;
  logic [1:0] st;
  logic [2:0] cf, bf;
  byte_type c2, ov, bc, iv, sl, pc, th, wd;
  byte_type rx[$];
  byte_type ex[$];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int rsts = 0;
  always #12.5 clk = ~clk;
  // Open-drain wire with pull-up.
  assign sda = hsda & (oe ? sdo : 1'b1);
  i2c_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  charger_i2c_register_bank dut (
    .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe),
    .CHARGE_STATE_IN(st), .BOOST_ACTIVE_IN(bst), .CHARGER_FAULT_IN(cf), .BOOST_FAULT_IN(bf),
    .CHARGING_IN(chg), .FAULT_EVENT_IN(flt), .PART_INFORMATION_IN(8'h5C),
    .LIVE_MONITOR_FIRST_IN(8'h6D), .LIVE_MONITOR_SECOND_IN(8'h7E),
    .SAFETY_TIMER_RESTART_OUT(rs), .STAT_ENABLE_OUT(en), .STAT_N_OUT(stn),
    .CHARGER_CONTROL_SECOND_OUT(c2), .OUTPUT_VOLTAGE_SETTING_OUT(ov), .BATTERY_CURRENT_SETTING_OUT(bc),
    .INPUT_VOLTAGE_CONTROL_OUT(iv), .SAFETY_LIMITS_OUT(sl), .POST_CHARGE_CONTROL_OUT(pc),
    .THERMISTOR_CONTROL_OUT(th), .WATCHDOG_CONTROL_OUT(wd)
  );
  always @(posedge clk) begin
    if (rs === 1'b1) rsts++;
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input byte_type g, input byte_type e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input byte_type i, input byte_type d[$]);
    host.start();
    host.send(8'hD6, ack);
    cmp({7'h00, ack}, 8'h00);
    host.send(i, ack);
    foreach (d[k]) host.send(d[k], ack);
    cmp({7'h00, ack}, 8'h00);
    host.stop();
  endtask
  task automatic rd(input byte_type i, input int n);
    byte_type b;
    rx = {};
    host.start();
    host.send(8'hD6, ack);
    host.send(i, ack);
    host.start();
    host.send(8'hD7, ack);
    for (int k = 0; k < n; k++) begin
      host.recv(b, k == n - 1);
      rx.push_back(b);
    end
    host.stop();
  endtask
  function automatic byte_type e0(input logic e);
    return {1'b0, e, st, bst, bst ? bf : cf};
  endfunction
  initial begin
    {st, bst, cf, bf, chg, flt} = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp({7'h00, en}, 8'h01);
    cmp(c2, 8'h00);
    rd(8'h00, 1);
    cmp(rx[0], 8'h40);
    host.start();
    host.send(8'hD4, ack);
    host.stop();
    cmp({7'h00, ack}, 8'h01);
    $display("reset and address test done");
    wr(8'h01, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77});
    rd(8'h00, 8);
    foreach (rx[k]) cmp(rx[k], k == 0 ? e0(1'b1) : k == 3 ? 8'h5C : 8'(k * 17));
    cmp(c2, 8'h11);
    cmp(ov, 8'h22);
    cmp(bc, 8'h44);
    cmp(iv, 8'h55);
    cmp(sl, 8'h66);
    cmp(pc, 8'h77);
    wr(8'h11, '{8'h99, 8'hA5, 8'h3C, 8'h77});
    rd(8'h10, 5);
    ex = '{8'h6D, 8'h7E, 8'hA5, 8'h3C, 8'h00};
    foreach (rx[k]) cmp(rx[k], ex[k]);
    cmp(th, 8'hA5);
    cmp(wd, 8'h3C);
    $display("sequential access test done");
    wr(8'h00, '{8'hBF});
    cmp(8'(rsts), 8'h01);
    cmp({7'h00, en}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      st = 2'(i);
      bst = i[0];
      cf = 3'(i);
      bf = 3'(7 - i);
      rd(8'h00, 1);
      cmp(rx[0], e0(1'b0));
    end
    wr(8'h00, '{8'h3F});
    cmp(8'(rsts), 8'h01);
    chg = 1'b1;
    repeat (3) @(negedge clk);
    cmp({7'h00, stn}, 8'h01);
    wr(8'hFF, '{8'hEE, 8'h40});
    cmp({7'h00, en}, 8'h01);
    cmp({7'h00, stn}, 8'h00);
    chg = 1'b0;
    repeat (3) @(negedge clk);
    flt = 1'b1;
    @(negedge clk);
    flt = 1'b0;
    repeat (39) @(negedge clk);
    cmp({7'h00, stn}, 8'h00);
    @(negedge clk);
    cmp({7'h00, stn}, 8'h01);
    $display("status test done");
    conclude();
  end
endmodule
